//--- hw/fapc_flash_access_protect_ctrl.sv
// flash control register, launch sequencer, lock levels and access decode
module fapc_flash_access_protect_ctrl
   import fapc_pkg::*;
#(
   parameter int ERASE_CYCLES = FAPC_ERASE_CYC,
   parameter int PROG_CYCLES = FAPC_PROG_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] flash_control_rdata,
   input wire logic instr_done,
   input wire logic par_prog_mode,
   input wire logic par_lock_wr,
   input wire logic [2:0] par_lock_wdata,
   input wire logic par_prog_req,
   input wire logic par_verify_req,
   output logic par_prog_allow,
   output logic par_verify_allow,
   input wire logic external_access_pin,
   output logic ext_access_latched,
   output logic [1:0] security_level,
   input wire logic [1:0] exec_from,
   input wire logic code_rollover,
   output logic ext_code_int_read_ok,
   output logic rollover_exec_ok,
   input wire logic eeprom_window_enable,
   output logic data_rd_eeprom,
   output logic data_wr_eeprom,
   output logic data_wr_latch,
   output logic [1:0] code_read_space,
   output logic [3:0] read_allow,
   output logic [3:0] write_allow,
   input wire logic cpu_idle,
   output logic flash_erase,
   output logic flash_program
);
   // read_allow/write_allow bits: 3 boot, 2 user, 1 eeprom, 0 security byte
   // write_allow bit 3 is the extra row instead of boot flash

   // counts must fit the 16-bit phase counter
   if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65535) begin : g_bad_erase
      $error("bad erase count");
   end
   if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_bad_prog
      $error("bad prog count");
   end

   logic [3:0] key_reg;
   logic latch_map_select_reg;
   logic [1:0] space_select_reg;
   logic program_in_progress_reg;
   // lock bits have no reset; they come up in the delivered state
   logic [2:0] lock_reg = FAPC_LOCK_DELIVERED;
   logic ext_access_reg;
   logic ext_access_taken_reg;
   fapc_state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [1:0] op_space_reg;

   wire ctl_wr = sfr_wr && (sfr_addr == FAPC_FLASH_CONTROL_ADDR);
   wire [3:0] wr_key = sfr_wdata[FAPC_KEY_HI:FAPC_KEY_LO];
   wire lock0 = lock_reg[0];
   wire lock1 = lock_reg[1];
   wire lock2 = lock_reg[2];
   wire level_ge2 = lock0 | lock1 | lock2;
   wire level_ge3 = lock1 | lock2;
   wire is_ext = (exec_from == FAPC_EXEC_EXT) || code_rollover;
   wire is_boot = (exec_from == FAPC_EXEC_BOOT) && !code_rollover;
   wire arm_ok = ctl_wr && (wr_key == FAPC_KEY_ARM);
   wire go_ok = ctl_wr && (wr_key == FAPC_KEY_GO) &&
                (sfr_wdata[FAPC_SPACE_HI:FAPC_SPACE_LO] !=
                 FAPC_SPACE_RSVD);
   wire [1:0] lvl_next = lock2 ? 2'h3 : lock1 ? 2'h2 : lock0 ? 2'h1 : 2'h0;

   // launch sequencer: arm, go, erase then program
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         FAPC_ST_IDLE: begin
            if (arm_ok) state_next = FAPC_ST_ARMED;
         end
         FAPC_ST_ARMED: begin
            if (go_ok) begin
               state_next = FAPC_ST_ERASE;
               cnt_next = 16'(ERASE_CYCLES - 1);
            end else if (arm_ok) begin
               state_next = FAPC_ST_ARMED;
            end else if (ctl_wr || instr_done) begin
               state_next = FAPC_ST_IDLE;
            end
         end
         FAPC_ST_ERASE: begin
            if (cnt_reg == 16'h0000) begin
               state_next = FAPC_ST_PROG;
               cnt_next = 16'(PROG_CYCLES - 1);
            end else begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
         FAPC_ST_PROG: begin
            if (cnt_reg == 16'h0000) state_next = FAPC_ST_IDLE;
            else cnt_next = cnt_reg - 16'h0001;
         end
         default: state_next = FAPC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         key_reg <= FAPC_FLASH_CONTROL_RESET[7:4];
         latch_map_select_reg <= 1'b0;
         space_select_reg <= 2'b00;
         program_in_progress_reg <= 1'b0;
         state_reg <= FAPC_ST_IDLE;
         cnt_reg <= 16'h0000;
         op_space_reg <= 2'b00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (ctl_wr) begin
            key_reg <= wr_key;
            latch_map_select_reg <= sfr_wdata[FAPC_LATCH_MAP_BIT];
            space_select_reg <= sfr_wdata[FAPC_SPACE_HI:FAPC_SPACE_LO];
         end
         if (state_reg == FAPC_ST_ARMED && go_ok)
            op_space_reg <= sfr_wdata[FAPC_SPACE_HI:FAPC_SPACE_LO];
         // busy follows the sequencer only; bit 0 of a write is dropped
         program_in_progress_reg <= (state_next == FAPC_ST_ERASE) ||
                                    (state_next == FAPC_ST_PROG);
      end
   end

   // lock bits: only parallel mode writes them; reset keeps them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_access_taken_reg <= 1'b0;
         ext_access_reg <= 1'b1;
      end else begin
         if (par_prog_mode && par_lock_wr && !level_ge2)
            lock_reg <= par_lock_wdata;
         if (!ext_access_taken_reg) begin
            ext_access_reg <= external_access_pin;
            ext_access_taken_reg <= 1'b1;
         end
      end
   end

   // latch-map overrides window for reads and writes; reads never see latches
   wire ea_eff_unused_guard = 1'b0;
   wire ext_access_eff = level_ge2 ? ext_access_reg : external_access_pin;
   wire rd_eep = eeprom_window_enable && !latch_map_select_reg;
   wire wr_eep = eeprom_window_enable && !latch_map_select_reg;
   wire wr_lat = latch_map_select_reg && ext_access_eff;

   wire [3:0] rd_allow_c = is_ext ? 4'b0010 : 4'b1111;
   // write bits: 3 extra row, 2 user flash, 1 eeprom, 0 security byte
   wire [3:0] wr_allow_c = is_ext ? 4'b0010 :
                           is_boot ? 4'b1111 :
                           {1'b1, cpu_idle, 1'b1, 1'b0};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flash_control_rdata <= FAPC_FLASH_CONTROL_RESET;
         par_prog_allow <= 1'b0;
         par_verify_allow <= 1'b0;
         ext_access_latched <= 1'b0;
         security_level <= 2'h0;
         ext_code_int_read_ok <= 1'b0;
         rollover_exec_ok <= 1'b0;
         data_rd_eeprom <= 1'b0;
         data_wr_eeprom <= 1'b0;
         data_wr_latch <= 1'b0;
         code_read_space <= FAPC_SPACE_USER;
         read_allow <= 4'h0;
         write_allow <= 4'h0;
         flash_erase <= 1'b0;
         flash_program <= 1'b0;
      end else begin
         flash_control_rdata <= {key_reg, latch_map_select_reg,
                                 space_select_reg,
                                 program_in_progress_reg};
         par_prog_allow <= par_prog_mode && par_prog_req &&
                           !level_ge2;
         par_verify_allow <= par_prog_mode && par_verify_req &&
                             !level_ge3;
         ext_access_latched <= ext_access_reg;
         security_level <= lvl_next;
         ext_code_int_read_ok <= !level_ge2;
         rollover_exec_ok <= !lock2;
         data_rd_eeprom <= rd_eep;
         data_wr_eeprom <= wr_eep;
         data_wr_latch <= wr_lat;
         code_read_space <= space_select_reg;
         read_allow <= rd_allow_c;
         write_allow <= wr_allow_c;
         flash_erase <= (state_next == FAPC_ST_ERASE);
         flash_program <= (state_next == FAPC_ST_PROG);
      end
   end

   busy_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == FAPC_ST_IDLE && !arm_ok) |=> !program_in_progress_reg)
      else $error("busy set without launch");
   launch_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == FAPC_ST_ARMED && go_ok) |=> program_in_progress_reg)
      else $error("launch did not set busy");
   abort_gap_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == FAPC_ST_ARMED && !ctl_wr && instr_done)
      |=> state_reg == FAPC_ST_IDLE)
      else $error("launch not aborted");
   erase_first_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(program_in_progress_reg) |-> flash_erase && !flash_program)
      else $error("program before erase");
   lock_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
      !par_prog_mode |=> $stable(lock_reg))
      else $error("lock bits changed by software");
   verify_block_a: assert property (@(posedge clock) disable iff (!rst_n)
      level_ge3 |=> !par_verify_allow)
      else $error("verify allowed when locked");
   prog_block_a: assert property (@(posedge clock) disable iff (!rst_n)
      level_ge2 |=> !par_prog_allow && !ext_code_int_read_ok)
      else $error("level 2 protection missing");
   data_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      latch_map_select_reg |=> !data_rd_eeprom)
      else $error("eeprom read with latch map");
   ext_only_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_ext |=> write_allow == 4'b0010 && read_allow == 4'b0010)
      else $error("external code reached flash");
   rollover_a: assert property (@(posedge clock) disable iff (!rst_n)
      lock2 |=> !rollover_exec_ok)
      else $error("roll-over allowed at level 4");
endmodule // fapc_flash_access_protect_ctrl

//--- hw/fapc_pkg.sv
// package with register layout, lock and space encodings for flash access
package fapc_pkg;
   localparam logic [7:0] FAPC_FLASH_CONTROL_ADDR = 8'hd1;
   localparam logic [7:0] FAPC_FLASH_CONTROL_RESET = 8'h00;
   localparam int FAPC_KEY_HI = 7;
   localparam int FAPC_KEY_LO = 4;
   localparam int FAPC_LATCH_MAP_BIT = 3;
   localparam int FAPC_SPACE_HI = 2;
   localparam int FAPC_SPACE_LO = 1;
   localparam int FAPC_BUSY_BIT = 0;
   localparam logic [3:0] FAPC_KEY_ARM = 4'h5;
   localparam logic [3:0] FAPC_KEY_GO = 4'ha;
   // delivered lock state: level 4 (lock bit two programmed, active high)
   localparam logic [2:0] FAPC_LOCK_DELIVERED = 3'h4;
   // erase and program phase lengths in ns (plain defaults)
   localparam int FAPC_ERASE_NS = 100;
   localparam int FAPC_PROG_NS = 100;
   localparam int FAPC_CLK_NS = 5;
   localparam int FAPC_ERASE_CYC =
      (FAPC_ERASE_NS + FAPC_CLK_NS - 1) / FAPC_CLK_NS;
   localparam int FAPC_PROG_CYC =
      (FAPC_PROG_NS + FAPC_CLK_NS - 1) / FAPC_CLK_NS;

   typedef enum logic [1:0] {
      FAPC_SPACE_USER = 2'b00,
      FAPC_SPACE_EXTRA_ROW = 2'b01,
      FAPC_SPACE_SECURITY = 2'b10,
      FAPC_SPACE_RSVD = 2'b11
   } fapc_space_t;

   typedef enum logic [1:0] {
      FAPC_ST_IDLE = 2'b00,
      FAPC_ST_ARMED = 2'b01,
      FAPC_ST_ERASE = 2'b10,
      FAPC_ST_PROG = 2'b11
   } fapc_state_t;

   typedef enum logic [1:0] {
      FAPC_EXEC_BOOT = 2'b00,
      FAPC_EXEC_USER = 2'b01,
      FAPC_EXEC_EXT = 2'b10
   } fapc_exec_t;
endpackage

//--- verification/fapc_prog_model.sv
// parallel programmer model: verify pass, then a lock write attempt
module fapc_prog_model (
   input wire logic clock,
   input wire logic go,
   input wire logic [2:0] lock_val,
   output logic par_prog_mode,
   output logic par_lock_wr,
   output logic [2:0] par_lock_wdata,
   output logic par_prog_req,
   output logic par_verify_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] step_reg = 3'h0;
   always_ff @(posedge clock) begin
      if (go || step_reg != 3'h0) step_reg <= step_reg + 3'h1;
   end
   // lock bits are only ever touched inside a programming session
   assign par_prog_mode = step_reg != 3'h0;
   assign par_verify_req = step_reg == 3'h2;
   assign par_prog_req = step_reg == 3'h3;
   assign par_lock_wr = step_reg == 3'h4;
   // data outside the strobe is not left at the last value
   assign par_lock_wdata = par_lock_wr ? lock_val : ~lock_val;
endmodule // fapc_prog_model

//--- verification/tb.sv
// self-checking bench for the flash access and protection control
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fapc_pkg::*;
   logic clock = 0, rst_n = 0, sfr_wr = 0, instr_done = 0, go = 0;
   logic [7:0] sfr_addr = FAPC_FLASH_CONTROL_ADDR, sfr_wdata = 8'h00;
   logic external_access_pin = 1, code_rollover = 1, cpu_idle = 0;
   logic eeprom_window_enable = 0;
   logic [1:0] exec_from = 2'h2;
   logic [2:0] lock_val = 3'h0;
   logic par_prog_mode, par_lock_wr, par_prog_req, par_verify_req;
   logic [2:0] par_lock_wdata;
   logic [7:0] flash_control_rdata;
   logic par_prog_allow, par_verify_allow, ext_access_latched;
   logic ext_code_int_read_ok, rollover_exec_ok, flash_erase, flash_program;
   logic data_rd_eeprom, data_wr_eeprom, data_wr_latch;
   logic [1:0] security_level, code_read_space;
   logic [3:0] read_allow, write_allow;
   logic [10:0] q[$];
   logic [7:0] rnd = 8'h50;
   int fails = 0, check_count = 0;
   fapc_flash_access_protect_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(4))
      dut_u (
      .clock(clock),
      .rst_n(rst_n),
      .sfr_wr(sfr_wr),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .flash_control_rdata(flash_control_rdata),
      .instr_done(instr_done),
      .par_prog_mode(par_prog_mode),
      .par_lock_wr(par_lock_wr),
      .par_lock_wdata(par_lock_wdata),
      .par_prog_req(par_prog_req),
      .par_verify_req(par_verify_req),
      .par_prog_allow(par_prog_allow),
      .par_verify_allow(par_verify_allow),
      .external_access_pin(external_access_pin),
      .ext_access_latched(ext_access_latched),
      .security_level(security_level),
      .exec_from(exec_from),
      .code_rollover(code_rollover),
      .ext_code_int_read_ok(ext_code_int_read_ok),
      .rollover_exec_ok(rollover_exec_ok),
      .eeprom_window_enable(eeprom_window_enable),
      .data_rd_eeprom(data_rd_eeprom),
      .data_wr_eeprom(data_wr_eeprom),
      .data_wr_latch(data_wr_latch),
      .code_read_space(code_read_space),
      .read_allow(read_allow),
      .write_allow(write_allow),
      .cpu_idle(cpu_idle),
      .flash_erase(flash_erase),
      .flash_program(flash_program)
   );
   fapc_prog_model prog_u (
      .clock(clock),
      .go(go),
      .lock_val(lock_val),
      .par_prog_mode(par_prog_mode),
      .par_lock_wr(par_lock_wr),
      .par_lock_wdata(par_lock_wdata),
      .par_prog_req(par_prog_req),
      .par_verify_req(par_verify_req)
   );
   initial forever #2.5 clock = ~clock;
   function automatic logic [7:0] lfsr(logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(logic [7:0] v);
      sfr_wr = 1;
      sfr_wdata = v;
      tick();
   endtask
   task automatic exp(logic [2:0] s, logic [7:0] v);
      q.push_back({s, v});
   endtask
   function automatic logic [7:0] pick(logic [2:0] s);
      case (s)
         3'h0: return flash_control_rdata;
         3'h1: return {7'h00, flash_control_rdata[0]};
         3'h2: return {6'h00, flash_erase, flash_program};
         3'h3: return {6'h00, security_level};
         3'h4: return {3'h0, par_prog_allow, par_verify_allow,
            ext_code_int_read_ok, rollover_exec_ok, ext_access_latched};
         3'h5: return {5'h00, data_rd_eeprom, data_wr_eeprom, data_wr_latch};
         3'h6: return {read_allow, write_allow};
         default: return {6'h00, code_read_space};
      endcase
   endfunction
   task automatic check(logic [7:0] got, logic [7:0] want);
      check_count++;
      if (got !== want) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin : watch_p
      logic [10:0] e;
      // outputs only move on rising edges, so the falling edge sees them settled
      forever begin
         @(negedge clock);
         while (q.size() > 0) begin
            e = q.pop_front();
            check(pick(e[10:8]), e[7:0]);
         end
      end
   end
   initial begin : dog_p
      #50000;
      fails++;
      finish_test();
   end
   initial begin : main_p
      tick(3);
      rst_n = 1;
      tick();
      exp(3'h0, FAPC_FLASH_CONTROL_RESET);
      exp(3'h3, 8'h03);
      exp(3'h4, 8'h01);
      go = 1;
      tick();
      go = 0;
      tick(2);
      exp(3'h4, 8'h01);
      tick();
      exp(3'h4, 8'h01);
      tick(4);
      exp(3'h3, 8'h03);
      for (int sp = 0; sp < 4; sp++) begin
         wr({FAPC_KEY_ARM, 1'b0, sp[1:0], 1'b0});
         wr({FAPC_KEY_GO, 1'b0, sp[1:0], 1'b0});
         sfr_wr = 0;
         tick();
         exp(3'h2, sp == 3 ? 8'h00 : 8'h02);
         tick();
         exp(3'h1, sp == 3 ? 8'h00 : 8'h01);
         repeat (40) if (sp != 3 && flash_program !== 1'b1) tick();
         exp(3'h2, sp == 3 ? 8'h00 : 8'h01);
         repeat (40) if (flash_control_rdata[0] !== 1'b0) tick();
         exp(3'h1, 8'h00);
      end
      wr(8'h52);
      sfr_wr = 0;
      instr_done = 1;
      tick();
      instr_done = 0;
      wr(8'ha2);
      sfr_wr = 0;
      tick(2);
      exp(3'h1, 8'h00);
      wr(8'h0d);
      sfr_wr = 0;
      tick(2);
      exp(3'h0, 8'h0c);
      exp(3'h7, 8'h02);
      for (int m = 1; m >= 0; m--) begin
         wr(m ? 8'h08 : 8'h00);
         sfr_wr = 0;
         repeat (4) begin
            rnd = lfsr(rnd);
            eeprom_window_enable = rnd[0];
            tick(2);
            exp(3'h5, {5'h00, rnd[0] & !m, rnd[0] & !m, m[0]});
         end
      end
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         exec_from = 2'(i % 3);
         code_rollover = i > 2;
         cpu_idle = rnd[0];
         tick(2);
         if (i % 3 == 2 || i > 2) exp(3'h6, 8'h22);
         else exp(3'h6, i == 0 ? 8'hff : {5'h1f, rnd[0], 2'h2});
      end
      // second reset with the access pin low: latched low, no latch writes
      external_access_pin = 0;
      rst_n = 0;
      tick(3);
      rst_n = 1;
      wr(8'h08);
      sfr_wr = 0;
      tick(2);
      exp(3'h4, 8'h00);
      exp(3'h5, 8'h00);
      exp(3'h0, 8'h08);
      exp(3'h3, 8'h03);
      tick();
      finish_test();
   end
endmodule // tb
